// >>> rtl/rmca_top.sv
// Real-mode cache attribute maps: register port and per-access lookup
`timescale 1ns/1ns
// What this block does
// - One data cacheable bit per 128 MB region
// - Bit 0 lowest region, bit 31 highest
// - Separate instruction cacheable bit per region
// - Per-region data write-back or write-through bit
module rmca_top #(
    parameter logic [31:0] P_RST_WPOL = rmca_pkg::RST_DATA_WRITE_POLICY_MAP,
    parameter logic [31:0] P_RST_DCACHE = rmca_pkg::RST_DATA_CACHEABLE_MAP,
    parameter logic [31:0] P_RST_ICACHE = rmca_pkg::RST_INSTR_CACHEABLE_MAP
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Special purpose register moves
    input wire logic i_spr_we,
    input wire logic i_spr_re,
    input wire logic [rmca_pkg::SPR_NUM_W-1:0] i_spr_num,
    input wire logic [rmca_pkg::REG_W-1:0] i_spr_wdata,
    output logic o_spr_hit,
    output logic o_spr_rvalid,
    output logic [rmca_pkg::REG_W-1:0] o_spr_rdata,
    // Data access lookup
    input wire logic i_dacc_valid,
    input wire logic i_dacc_real,
    input wire logic [rmca_pkg::ADDR_W-1:0] i_dacc_addr,
    output logic o_dacc_attr_valid,
    output rmca_pkg::rmca_dattr_t o_dacc_attr,
    // Instruction fetch lookup
    input wire logic i_ifetch_valid,
    input wire logic i_ifetch_real,
    input wire logic [rmca_pkg::ADDR_W-1:0] i_ifetch_addr,
    output logic o_ifetch_attr_valid,
    output logic o_ifetch_region_cacheable_bit
);
    import rmca_pkg::*;

    // ------------------------------------------------------------------
    // Map storage
    // ------------------------------------------------------------------
    rmca_maps_t maps; // Current contents of all three maps

    rmca_map_regs #(
        .P_RST_WPOL(P_RST_WPOL),
        .P_RST_DCACHE(P_RST_DCACHE),
        .P_RST_ICACHE(P_RST_ICACHE)
    ) u_map_regs (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_spr_we(i_spr_we),
        .i_spr_num(i_spr_num),
        .i_spr_wdata(i_spr_wdata),
        .o_maps(maps)
    );

    // ------------------------------------------------------------------
    // Register number decode
    // ------------------------------------------------------------------
    // Hit is a handshake term, so it may stay combinational
    always_comb begin
        case (i_spr_num)
            SPR_DATA_WRITE_POLICY_MAP: o_spr_hit = i_spr_we | i_spr_re;
            SPR_DATA_CACHEABLE_MAP: o_spr_hit = i_spr_we | i_spr_re;
            SPR_INSTR_CACHEABLE_MAP: o_spr_hit = i_spr_we | i_spr_re;
            default: o_spr_hit = 1'b0; // Not one of ours
        endcase
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic rd_valid_r; // Read answer strobe
    logic rd_valid_nxt;
    logic [REG_W-1:0] rd_data_r; // Read answer word
    logic [REG_W-1:0] rd_data_nxt;

    // A read samples the maps before any write of the same cycle lands
    always_comb begin
        rd_valid_nxt = i_spr_re;
        rd_data_nxt = READ_ZERO;
        if (i_spr_re) begin
            case (i_spr_num)
                SPR_DATA_WRITE_POLICY_MAP: rd_data_nxt = maps.write_policy;
                SPR_DATA_CACHEABLE_MAP: rd_data_nxt = maps.d_cacheable;
                SPR_INSTR_CACHEABLE_MAP: rd_data_nxt = maps.i_cacheable;
                default: rd_data_nxt = READ_ZERO; // Unmapped reads give zero
            endcase
        end
    end

    // Answer register; the data word holds until the next read
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rd_valid_r <= 1'b0;
            rd_data_r <= READ_ZERO;
        end else begin
            rd_valid_r <= rd_valid_nxt;
            if (rd_valid_nxt) begin
                rd_data_r <= rd_data_nxt;
            end
        end
    end

    assign o_spr_rvalid = rd_valid_r;
    assign o_spr_rdata = rd_data_r;

    // ------------------------------------------------------------------
    // Attribute lookup
    // ------------------------------------------------------------------
    logic [REGION_W-1:0] d_region; // Region of the data access
    logic [REGION_W-1:0] i_region; // Region of the fetch

    // Combinational on purpose: the caches need the bit in the access cycle,
    // at the cost of a path from address through a 32-to-1 mux
    assign d_region = i_dacc_addr[REGION_MSB:REGION_LSB];
    assign i_region = i_ifetch_addr[REGION_MSB:REGION_LSB];

    always_comb begin
        o_dacc_attr_valid = i_dacc_valid & i_dacc_real;
        o_ifetch_attr_valid = i_ifetch_valid & i_ifetch_real;
        // Bits are forced low when no real-mode access is asking
        o_dacc_attr.region_cacheable_bit = 1'b0;
        o_dacc_attr.region_write_through_bit = 1'b0;
        o_ifetch_region_cacheable_bit = 1'b0;
        if (o_dacc_attr_valid) begin
            o_dacc_attr.region_cacheable_bit =
                rmca_region_bit(maps.d_cacheable, d_region);
            o_dacc_attr.region_write_through_bit =
                rmca_region_bit(maps.write_policy, d_region);
        end
        if (o_ifetch_attr_valid) begin
            o_ifetch_region_cacheable_bit =
                rmca_region_bit(maps.i_cacheable, i_region);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    // A data-cacheable write shows on the next data access
    chk_dcache_after_write: assert property (
        (i_spr_we && i_spr_num == SPR_DATA_CACHEABLE_MAP) ##1 o_dacc_attr_valid
        |-> o_dacc_attr.region_cacheable_bit ==
            rmca_region_bit($past(i_spr_wdata), d_region))
        else $error("data cacheable bit does not follow written map");

    // Region zero reads the leftmost bit, region 31 the rightmost
    chk_region_order_low: assert property (
        (o_dacc_attr_valid && d_region == 5'h00)
        |-> o_dacc_attr.region_cacheable_bit == maps.d_cacheable[31])
        else $error("lowest region not tied to bit 0");

    chk_region_order_high: assert property (
        (o_ifetch_attr_valid && i_region == 5'h1f)
        |-> o_ifetch_region_cacheable_bit == maps.i_cacheable[0])
        else $error("highest region not tied to bit 31");

    // An instruction-cacheable write shows on the next fetch
    chk_icache_after_write: assert property (
        (i_spr_we && i_spr_num == SPR_INSTR_CACHEABLE_MAP) ##1 o_ifetch_attr_valid
        |-> o_ifetch_region_cacheable_bit ==
            rmca_region_bit($past(i_spr_wdata), i_region))
        else $error("instruction cacheable bit does not follow written map");

    // A write-policy write shows on the next data access
    chk_wpol_after_write: assert property (
        (i_spr_we && i_spr_num == SPR_DATA_WRITE_POLICY_MAP) ##1 o_dacc_attr_valid
        |-> o_dacc_attr.region_write_through_bit ==
            rmca_region_bit($past(i_spr_wdata), d_region))
        else $error("write-through bit does not follow written map");

    // Lookup answers in the access cycle, only for real-mode requests
    chk_same_cycle_valid: assert property (
        o_dacc_attr_valid == (i_dacc_valid && i_dacc_real) &&
        o_ifetch_attr_valid == (i_ifetch_valid && i_ifetch_real))
        else $error("attribute valid not in the access cycle");

    // Write then read of the data-cacheable map returns the written word
    chk_read_back: assert property (
        (i_spr_we && i_spr_num == SPR_DATA_CACHEABLE_MAP) ##1
        (i_spr_re && !i_spr_we && i_spr_num == SPR_DATA_CACHEABLE_MAP)
        |=> o_spr_rvalid && o_spr_rdata == $past(i_spr_wdata, 2))
        else $error("read back differs from written word");

    // Maps do not move without a write
    chk_maps_hold: assert property (
        !i_spr_we |=> $stable(maps))
        else $error("map changed without a write");

    // Unmapped reads answer zero one cycle later
    chk_unmapped_zero: assert property (
        (i_spr_re && !o_spr_hit) |=> o_spr_rvalid && o_spr_rdata == READ_ZERO)
        else $error("unmapped read not answered with zero");

    cov_dcache_hit: cover property (
        o_dacc_attr_valid && o_dacc_attr.region_cacheable_bit);
    cov_write_through: cover property (
        o_dacc_attr_valid && o_dacc_attr.region_write_through_bit);
    cov_ifetch_cacheable: cover property (
        o_ifetch_attr_valid && o_ifetch_region_cacheable_bit);
    cov_write_read: cover property (
        (i_spr_we && o_spr_hit) ##1 (i_spr_re && o_spr_hit));

endmodule : rmca_top

// >>> rtl/rmca_pkg.sv
// Package: register numbers, widths, reset values and types of the real-mode attribute maps
package rmca_pkg;

    // ------------------------------------------------------------------
    // Register numbers on the special purpose register move port
    // ------------------------------------------------------------------
    localparam int SPR_NUM_W = 10;
    localparam logic [SPR_NUM_W-1:0] SPR_DATA_WRITE_POLICY_MAP = 10'h3ba;
    localparam logic [SPR_NUM_W-1:0] SPR_DATA_CACHEABLE_MAP = 10'h3fa;
    localparam logic [SPR_NUM_W-1:0] SPR_INSTR_CACHEABLE_MAP = 10'h3fb;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int REG_W = 32;
    localparam int ADDR_W = 32;
    localparam int REGION_W = 5;
    // Region index is taken from the top five address bits
    localparam int REGION_MSB = 31;
    localparam int REGION_LSB = 27;
    // Bit 0 is the leftmost bit of the word, so region n sits at vector bit 31-n
    localparam logic [REGION_W-1:0] REGION_TOP_BIT = 5'h1f;

    // ------------------------------------------------------------------
    // Reset values (all regions non-cacheable and write-back)
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_DATA_WRITE_POLICY_MAP = 32'h0000_0000;
    localparam logic [REG_W-1:0] RST_DATA_CACHEABLE_MAP = 32'h0000_0000;
    localparam logic [REG_W-1:0] RST_INSTR_CACHEABLE_MAP = 32'h0000_0000;
    localparam logic [REG_W-1:0] READ_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // The three attribute maps travel together
    typedef struct packed {
        logic [REG_W-1:0] write_policy;
        logic [REG_W-1:0] d_cacheable;
        logic [REG_W-1:0] i_cacheable;
    } rmca_maps_t;

    // Attributes handed to the data cache for one access
    typedef struct packed {
        logic region_cacheable_bit;
        logic region_write_through_bit;
    } rmca_dattr_t;

    // Pick the bit of one region out of a map
    function automatic logic rmca_region_bit(input logic [REG_W-1:0] map,
                                             input logic [REGION_W-1:0] region);
        return map[REGION_TOP_BIT - region];
    endfunction : rmca_region_bit

endpackage : rmca_pkg

// >>> rtl/rmca_map_regs.sv
// Storage of the three real-mode attribute maps with their write port
`timescale 1ns/1ns
module rmca_map_regs #(
    parameter logic [31:0] P_RST_WPOL = rmca_pkg::RST_DATA_WRITE_POLICY_MAP,
    parameter logic [31:0] P_RST_DCACHE = rmca_pkg::RST_DATA_CACHEABLE_MAP,
    parameter logic [31:0] P_RST_ICACHE = rmca_pkg::RST_INSTR_CACHEABLE_MAP
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_spr_we,
    input wire logic [rmca_pkg::SPR_NUM_W-1:0] i_spr_num,
    input wire logic [rmca_pkg::REG_W-1:0] i_spr_wdata,
    output rmca_pkg::rmca_maps_t o_maps
);
    import rmca_pkg::*;

    rmca_maps_t maps_r; // Current maps
    rmca_maps_t maps_nxt; // Maps after this cycle

    // ------------------------------------------------------------------
    // Next-value logic
    // ------------------------------------------------------------------
    // A write replaces the whole word; there are no byte lanes on this port
    always_comb begin
        maps_nxt = maps_r;
        if (i_spr_we) begin
            case (i_spr_num)
                SPR_DATA_WRITE_POLICY_MAP: maps_nxt.write_policy = i_spr_wdata;
                SPR_DATA_CACHEABLE_MAP: maps_nxt.d_cacheable = i_spr_wdata;
                SPR_INSTR_CACHEABLE_MAP: maps_nxt.i_cacheable = i_spr_wdata;
                default: maps_nxt = maps_r; // Other numbers belong elsewhere
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            maps_r.write_policy <= P_RST_WPOL;
            maps_r.d_cacheable <= P_RST_DCACHE;
            maps_r.i_cacheable <= P_RST_ICACHE;
        end else begin
            maps_r <= maps_nxt;
        end
    end

    assign o_maps = maps_r;

endmodule : rmca_map_regs

// >>> bench/rmca_cache_model.sv
// Model of the core cache logic that issues real-mode attribute lookups
`timescale 1ns/1ns
module rmca_cache_model (
    input wire logic i_core_clk,
    input wire logic i_req,
    input wire logic i_real,
    input wire logic [31:0] i_addr,
    output logic o_valid,
    output logic o_real,
    output logic [31:0] o_daddr,
    output logic [31:0] o_iaddr
);
    // ------------------------------------------------------------
    // Lookup launch, one cycle after the bench asks
    // ------------------------------------------------------------
    initial begin
        o_valid = 1'b0;
        o_real = 1'b0;
        o_daddr = 32'h0000_0000;
        o_iaddr = 32'hffff_ffff;
    end
    // Idle address lines toggle, so a stale address never looks like a live one
    always @(negedge i_core_clk) begin
        o_valid <= i_req;
        o_real <= i_real;
        o_daddr <= i_req ? i_addr : ~o_daddr;
        // Fetch side uses the mirrored region, so two regions are probed per cycle
        o_iaddr <= i_req ? ~i_addr : ~o_iaddr;
    end
endmodule : rmca_cache_model

// >>> bench/testbench.sv
// Self-checking testbench for the real-mode cache attribute maps
`timescale 1ns/1ns
module testbench;
    import rmca_pkg::*;
    // ------------------------------------------------------------
    // Signals and bench state
    // ------------------------------------------------------------
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic we = 1'b0, re = 1'b0, req = 1'b0, rl = 1'b0;
    logic [9:0] num = 10'h000;
    logic [31:0] wdata = 32'h0000_0000, addr = 32'h0000_0000;
    logic hit, rvalid, dvalid, ivalid, ibit, pv, pr;
    logic [31:0] rdata, daddr, iaddr;
    rmca_dattr_t dattr;
    logic [31:0] mdl [3]; // Expected maps: write policy, data, instruction
    logic [31:0] rq [$]; // Expected read words
    logic [2:0] lq [$]; // Expected lookup bits
    logic [9:0] nums [3] = '{SPR_DATA_WRITE_POLICY_MAP, SPR_DATA_CACHEABLE_MAP,
                             SPR_INSTR_CACHEABLE_MAP};
    int err_total = 0, n_tests = 0, cyc = 0, seed = 32'h772f;
    always #10 i_core_clk = ~i_core_clk;
    // ------------------------------------------------------------
    // Design and partner
    // ------------------------------------------------------------
    rmca_top rmca_top_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_spr_we(we),
        .i_spr_re(re), .i_spr_num(num), .i_spr_wdata(wdata), .o_spr_hit(hit),
        .o_spr_rvalid(rvalid), .o_spr_rdata(rdata), .i_dacc_valid(pv), .i_dacc_real(pr),
        .i_dacc_addr(daddr), .o_dacc_attr_valid(dvalid), .o_dacc_attr(dattr),
        .i_ifetch_valid(pv), .i_ifetch_real(pr), .i_ifetch_addr(iaddr),
        .o_ifetch_attr_valid(ivalid), .o_ifetch_region_cacheable_bit(ibit));
    rmca_cache_model rmca_cache_model_inst (.i_core_clk(i_core_clk), .i_req(req),
        .i_real(rl), .i_addr(addr), .o_valid(pv), .o_real(pr), .o_daddr(daddr),
        .o_iaddr(iaddr));
    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    // Unknown numbers map to no slot; reads of them give zero
    function automatic int slot(input logic [9:0] n);
        for (int i = 0; i < 3; i++) if (n == nums[i]) return i;
        return 3;
    endfunction : slot
    // One register move, strobe held a single cycle, then one idle cycle
    task automatic spr_op(input logic w, input logic r, input logic [9:0] n,
                          input logic [31:0] d);
        int s;
        s = slot(n);
        we <= w;
        re <= r;
        num <= n;
        wdata <= d;
        // A read in the same cycle as a write still sees the old word
        if (r) rq.push_back(s < 3 ? mdl[s] : READ_ZERO);
        if (w && s < 3) mdl[s] = d;
        @(negedge i_core_clk);
        we <= 1'b0;
        re <= 1'b0;
        @(negedge i_core_clk);
    endtask : spr_op
    // Write, then read back in the very next cycle with no idle gap
    // A lookup launched with the write reaches the design the cycle after it lands
    task automatic spr_wr_rd(input logic [9:0] n, input logic [31:0] d,
                             input logic [31:0] a);
        we <= 1'b1;
        num <= n;
        wdata <= d;
        addr <= a;
        req <= 1'b1;
        rl <= 1'b1;
        mdl[slot(n)] = d;
        rq.push_back(d);
        // Fetch side probes the mirrored region, so its vector bit equals the region
        lq.push_back({mdl[1][31-a[31:27]], mdl[0][31-a[31:27]], mdl[2][a[31:27]]});
        @(negedge i_core_clk);
        we <= 1'b0;
        re <= 1'b1;
        req <= 1'b0;
        @(negedge i_core_clk);
        re <= 1'b0;
        @(negedge i_core_clk);
    endtask : spr_wr_rd
    // ------------------------------------------------------------
    // Output watcher: pops the oldest note when a result shows
    // ------------------------------------------------------------
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
        if (i_rst_n) begin
            if (we | re) check(hit, slot(num) < 3);
            if (rvalid === 1'b1) check(rdata, rq.size() ? rq.pop_front() : ~rdata);
            check({dvalid, ivalid}, {2{pv & pr}});
            if (dvalid === 1'b1) check({dattr, ibit}, lq.size() ? lq.pop_front() : 3'h0);
            else check({dattr, ibit}, 3'h0);
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        mdl = '{RST_DATA_WRITE_POLICY_MAP, RST_DATA_CACHEABLE_MAP, RST_INSTR_CACHEABLE_MAP};
        repeat (3) @(negedge i_core_clk);
        i_rst_n <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            // Reset values first, then unmapped number: write ignored, read gives zero
            for (int i = 0; i < 3; i++) spr_op(1'b0, 1'b1, nums[i], 32'h0000_0000);
            spr_op(1'b1, 1'b0, 10'h3fc, $random(seed));
            spr_op(1'b0, 1'b1, 10'h3fc, 32'h0000_0000);
            for (int i = 0; i < 3; i++) spr_op(1'b1, 1'b0, nums[i], $random(seed));
            for (int i = 0; i < 3; i++) spr_op(1'b0, 1'b1, nums[i], 32'h0000_0000);
            spr_op(1'b1, 1'b1, nums[k], $random(seed));
            // Back-to-back write and read, plus a lookup right after the write
            spr_wr_rd(nums[k], $random(seed), $random(seed));
            // Every region once; region 5 probed outside real mode
            for (int n = 0; n < 32; n++) begin
                addr <= {n[4:0], 27'($random(seed))};
                req <= 1'b1;
                rl <= (n != 5);
                if (n != 5) lq.push_back({mdl[1][31-n], mdl[0][31-n], mdl[2][n]});
                @(negedge i_core_clk);
            end
            req <= 1'b0;
            repeat (2) @(negedge i_core_clk);
            // Reset again in mid-run; maps must fall back
            i_rst_n <= 1'b0;
            mdl = '{RST_DATA_WRITE_POLICY_MAP, RST_DATA_CACHEABLE_MAP, RST_INSTR_CACHEABLE_MAP};
            @(negedge i_core_clk);
            i_rst_n <= 1'b1;
        end
        check(rq.size() + lq.size(), 32'h0000_0000);
        tally_and_finish();
    end
endmodule : testbench
